//--- design/fgc_pkg.sv
//Contract
//- the top five code bits, msb first, give the filter corner in MHz, 1 to 31 in 1 MHz steps.
//- a frequency code of zero passes no signal instead of choosing a corner.
//- code bit 2 picks the preamp gain of both channels, 3 dB when clear and 6 dB when set.
//- code bit 1 picks the postamp gain, 6 dB when clear and 12 dB when set.
//- code bit 0 picks the vga maximum gain, 22 dB when clear and 28 dB when set.
//- one shared copy of the settings drives identical values to both channels.
//- with the chip enable pin low the channels are inactive and writes are dropped, though reads still return the code; the host drives it high to run.
//- a frame opens with frame select low and the first rising serial edge picks write on 1, read on 0.
//- a write takes eight bits lsb first on the next eight rising edges and applies them when the frame closes.
//- a read shifts the stored code out lsb first on the next eight falling edges, ending with the frame.
package fgc_pkg;
  localparam int CODE_W = 8;
  localparam int FREQ_W = 5;
  localparam int FREQ_LSB = 3;
  localparam int PRE_BIT = 2;
  localparam int POST_BIT = 1;
  localparam int VGA_BIT = 0;
  localparam int NUM_CHAN = 2;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] MODE_EDGE = 4'h1;
  localparam logic [3:0] LAST_DATA_EDGE = 4'h9;
  localparam logic [3:0] READ_BITS = 4'h8;
  localparam logic [3:0] PRE_LO_DB = 4'h3;
  localparam logic [3:0] PRE_HI_DB = 4'h6;
  localparam logic [3:0] POST_LO_DB = 4'h6;
  localparam logic [3:0] POST_HI_DB = 4'hC;
  localparam logic [4:0] VGA_LO_DB = 5'h16;
  localparam logic [4:0] VGA_HI_DB = 5'h1C;
  localparam logic [4:0] FREQ_OFF = 5'h00;

  // settings handed to one analog channel
  typedef struct packed {
    logic active;
    logic pass;
    logic [4:0] cornerMhz;
    logic [3:0] preampDb;
    logic [3:0] postampDb;
    logic [4:0] vgaMaxDb;
  } fgc_chan_t;

  localparam fgc_chan_t CHAN_RESET = '{active: 1'b0, pass: 1'b0, cornerMhz: 5'h00,
    preampDb: 4'h0, postampDb: 4'h0, vgaMaxDb: 5'h00};
endpackage : fgc_pkg

//--- design/fgc_config_reg.sv
`timescale 1ns/100ps
module fgc_config_reg (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic reset_n, // reset, active low; synchronous for the mclk logic, asynchronous for the serial write capture
  input wire logic serialClk, // serial port clock from host
  input wire logic frame_select_n, // frame select, low during a transfer
  input wire logic serialDataIn, // serial data from host
  input wire logic chip_enable_pin, // chip enable pin, high to run
  output logic serialDataOut, // serial readback, changes on falling edge
  output logic [7:0] appliedCode, // code in force
  output fgc_pkg::fgc_chan_t [1:0] chanCfg // decoded settings per channel
);
  import fgc_pkg::*;

  logic [3:0] bitCnt_q;
  logic isRead_q;
  logic [7:0] shift_q;
  logic [7:0] wrWord_q;
  logic wrTgl_q;
  logic [3:0] rdIdx_q;
  logic [2:0] tglSync_q;
  logic [1:0] frameSync_q;
  logic [1:0] enSync_q;
  logic pending_q;
  logic [7:0] code_q;
  logic [7:0] code_d;
  fgc_chan_t chan_d;

  // decode of a code word, shared by every channel
  function automatic fgc_chan_t decodeCode(input logic [7:0] c, input logic en);
    fgc_chan_t r;
    logic [4:0] f;
    f = c[FREQ_LSB +: FREQ_W];
    r.active = en;
    r.pass = en && (f != FREQ_OFF);
    r.cornerMhz = f;
    r.preampDb = c[PRE_BIT] ? PRE_HI_DB : PRE_LO_DB;
    r.postampDb = c[POST_BIT] ? POST_HI_DB : POST_LO_DB;
    r.vgaMaxDb = c[VGA_BIT] ? VGA_HI_DB : VGA_LO_DB;
    return r;
  endfunction : decodeCode

  // rising-edge frame counter; frame high clears it since no clock runs then
  always_ff @(posedge serialClk or posedge frame_select_n) begin
    if (frame_select_n) begin
      bitCnt_q <= BIT_CNT_RESET;
    end else if (bitCnt_q != LAST_DATA_EDGE) begin
      bitCnt_q <= bitCnt_q + 4'h1;
    end
  end

  // mode bit taken on the first rising edge of the frame
  always_ff @(posedge serialClk or posedge frame_select_n) begin
    if (frame_select_n) begin
      isRead_q <= 1'b0;
    end else if (bitCnt_q == BIT_CNT_RESET) begin
      isRead_q <= ~serialDataIn;
    end
  end

  // write data shifts in lsb first, away from the applied code
  always_ff @(posedge serialClk) begin
    if (!isRead_q && bitCnt_q != BIT_CNT_RESET && bitCnt_q != LAST_DATA_EDGE) begin
      shift_q <= {serialDataIn, shift_q[7:1]};
    end
  end

  // full word captured only at the eighth data bit; toggle tells mclk
  always_ff @(posedge serialClk or negedge reset_n) begin
    if (!reset_n) begin
      wrWord_q <= CODE_RESET;
      wrTgl_q <= 1'b0;
    end else if (!frame_select_n && !isRead_q && bitCnt_q == READ_BITS) begin
      wrWord_q <= {serialDataIn, shift_q[7:1]};
      wrTgl_q <= ~wrTgl_q;
    end
  end

  // readback on falling edges; code_q cannot change while the frame is open
  always_ff @(negedge serialClk or posedge frame_select_n) begin
    if (frame_select_n) begin
      rdIdx_q <= BIT_CNT_RESET;
      serialDataOut <= 1'b0;
    end else if (isRead_q && rdIdx_q != READ_BITS) begin
      serialDataOut <= code_q[rdIdx_q[2:0]];
      rdIdx_q <= rdIdx_q + 4'h1;
    end
  end

  // synchronisers into mclk; only the last stages feed logic, the last two for the write toggle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tglSync_q <= 3'h0;
      frameSync_q <= 2'h3;
      enSync_q <= 2'h0;
    end else begin
      tglSync_q <= {tglSync_q[1:0], wrTgl_q};
      frameSync_q <= {frameSync_q[0], frame_select_n};
      enSync_q <= {enSync_q[0], chip_enable_pin};
    end
  end

  // a finished write waits here until the frame closes; a new word wins over the clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pending_q <= 1'b0;
    end else if (tglSync_q[2] != tglSync_q[1]) begin
      pending_q <= 1'b1;
    end else if (frameSync_q[1]) begin
      pending_q <= 1'b0;
    end
  end

  // apply at frame close; ignored while the chip is disabled
  always_comb begin
    code_d = code_q;
    if (pending_q && frameSync_q[1] && enSync_q[1]) begin
      code_d = wrWord_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      code_q <= CODE_RESET;
    end else begin
      code_q <= code_d;
    end
  end

  assign chan_d = decodeCode(code_d, enSync_q[1]);

  // one decoded copy fanned to both channels keeps them matched
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      appliedCode <= CODE_RESET;
      chanCfg <= {NUM_CHAN{CHAN_RESET}};
    end else begin
      appliedCode <= code_d;
      chanCfg <= {NUM_CHAN{chan_d}};
    end
  end
endmodule : fgc_config_reg

//--- dv/fgc_checker.sv
`timescale 1ns/100ps
module fgc_checker import fgc_pkg::*; (
  input wire logic mclk, // clock
  input wire logic reset_n, // reset
  input wire logic frame_select_n, // frame
  input wire logic chip_enable_pin, // enable
  input wire logic [7:0] appliedCode, // code
  input wire fgc_chan_t [1:0] chanCfg // settings
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  fgc_chan_t ch;
  // one lane stands for both, since chk_lane_match ties them
  assign ch = chanCfg[0];
  chk_lane_match: assert property (chanCfg[0] == chanCfg[1]) else $error("lanes");
  chk_corner_code: assert property (ch.active |-> ch.cornerMhz == appliedCode[7:3]) else $error("freq");
  chk_zero_mute: assert property (appliedCode[7:3] == 5'h0 |-> !ch.pass) else $error("mute");
  chk_pre_gain: assert property (ch.active |-> ch.preampDb == (appliedCode[2] ? 4'h6 : 4'h3)) else $error("pre");
  chk_post_gain: assert property (ch.active |-> ch.postampDb == (appliedCode[1] ? 4'hC : 4'h6)) else $error("post");
  chk_vga_gain: assert property (ch.active |-> ch.vgaMaxDb == (appliedCode[0] ? 5'h1C : 5'h16)) else $error("vga");
  chk_off_idle: assert property (!chip_enable_pin [*4] |=> !ch.active && !ch.pass) else $error("off");
  chk_code_hold: assert property (!frame_select_n [*3] |=> $stable(appliedCode)) else $error("hold");
  cover property ($changed(appliedCode));
  cover property (!ch.active ##1 ch.active);
  cover property (!frame_select_n ##1 frame_select_n);
endmodule : fgc_checker

//--- dv/fgc_host.sv
`timescale 1ns/100ps
module fgc_host (
  output logic serialClk = 1'b0, // stands still between frames
  output logic frame_select_n = 1'b1, // low within a frame
  output logic serialDataIn = 1'b0, // data to device
  input wire logic serialDataOut // readback
);
  // mode bit then n bits lsb first; data moves only while clock is low
  task xfer(input logic w, input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    frame_select_n = 1'b0;
    for (int i = -1; i < n; i++) begin
      serialDataIn = (i < 0) ? w : d[i];
      #12 serialClk = 1'b1;
      if (i >= 0) q[i] = serialDataOut;
      #24 serialClk = 1'b0;
      #12;
    end
    frame_select_n = 1'b1;
    serialDataIn = ~serialDataIn; // no stale level once released
    #50;
  endtask : xfer
endmodule : fgc_host

//--- dv/filter_gain_config_register_bench.sv
`timescale 1ns/100ps
module filter_gain_config_register_bench;
  import fgc_pkg::*;
  logic mclk = 0, reset_n, chip_enable_pin = 1, serialClk, frame_select_n, serialDataIn, serialDataOut;
  logic [7:0] appliedCode, rd, c;
  logic [7:0] cv [3] = '{8'hA5, 8'h5A, 8'h07};
  fgc_chan_t [1:0] chanCfg;
  int bad_count = 0, samples_checked = 0;
  fgc_config_reg dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .serialClk(serialClk),
    .frame_select_n(frame_select_n),
    .serialDataIn(serialDataIn),
    .chip_enable_pin(chip_enable_pin),
    .serialDataOut(serialDataOut),
    .appliedCode(appliedCode),
    .chanCfg(chanCfg)
  );
  fgc_host host (
    .serialClk(serialClk),
    .frame_select_n(frame_select_n),
    .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut)
  );
  // system clock
  initial forever #5 mclk = ~mclk;
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %0t value %h expected %h", $time, g, e);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // frame, then room for the sync and apply delay
  task wr(input logic [7:0] d, input int n);
    host.xfer(1'b1, d, n, rd);
    repeat (8) @(negedge mclk);
  endtask : wr
  // watchdog, several times the expected run
  initial begin
    #30000 bad_count++;
    stop_test;
  end
  // sequence
  initial begin
    // a real falling edge, or the serial side's asynchronous clear never fires
    #1 reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      c = cv[i];
      wr(c, 8);
      chk(appliedCode, c);
      chk(chanCfg[0].cornerMhz, c[7:3]);
      chk(chanCfg[0].pass, |c[7:3]);
      chk(chanCfg[0].preampDb, c[2] ? 8'h06 : 8'h03);
      chk(chanCfg[0].postampDb, c[1] ? 8'h0C : 8'h06);
      chk(chanCfg[0].vgaMaxDb, c[0] ? 8'h1C : 8'h16);
      chk(chanCfg[1] === chanCfg[0], 1'b1);
      host.xfer(1'b0, 8'h00, 8, rd);
      chk(rd, c);
    end
    wr(8'hF0, 5);
    chk(appliedCode, 8'h07);
    chip_enable_pin = 0;
    wr(8'h11, 8);
    chk(appliedCode, 8'h07);
    chk({6'h00, chanCfg[0].active, chanCfg[0].pass}, 8'h00);
    chip_enable_pin = 1;
    repeat (4) @(negedge mclk);
    chk(chanCfg[0].active, 1'b1);
    chk(appliedCode, 8'h07);
    stop_test;
  end
endmodule : filter_gain_config_register_bench
bind fgc_config_reg fgc_checker chk_i (
  .mclk(mclk),
  .reset_n(reset_n),
  .frame_select_n(frame_select_n),
  .chip_enable_pin(chip_enable_pin),
  .appliedCode(appliedCode),
  .chanCfg(chanCfg)
);
